// >>> rtl/ltc_pkg.sv
// shared constants and types of the logic timer and counter blocks
package ltc_pkg;
    // logic tick: 1 ms at 40 MHz sys_clk
    localparam int unsigned TICK_TIME_NS  = 1000000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    // default field widths
    localparam int unsigned TIME_WIDTH    = 16;
    localparam int unsigned COUNT_WIDTH   = 16;
    localparam int unsigned EVENT_COUNT   = 4;
    // default presets, in ticks and in counts
    localparam int unsigned PRESET_TIME_DEFAULT  = 10;
    localparam int unsigned PRESET_COUNT_DEFAULT = 5;
    // reset values
    localparam logic        OUT_RESET     = 1'b0;
    // gate kinds of a grid position
    typedef enum logic [2:0] {
        LTC_GATE_AND  = 3'b000,
        LTC_GATE_OR   = 3'b001,
        LTC_GATE_XOR  = 3'b010,
        LTC_GATE_NAND = 3'b011,
        LTC_GATE_NOR  = 3'b100,
        LTC_GATE_XNOR = 3'b101
    } ltc_gate_type;
endpackage

// >>> rtl/ltc_tick_gen.sv
// divider producing the one-cycle logic tick enable
`timescale 1ns/1ps
module ltc_tick_gen
    import ltc_pkg::*;
#(
    parameter int unsigned DIVIDE = TICK_CYCLES
)
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic sync_clear,
    output logic      tick
);
    localparam int unsigned CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } ltc_div_state_type;

    ltc_div_state_type state;
    ltc_div_state_type next_state;

    if (DIVIDE < 1)
    begin
        $error("tick divide must be at least one");
    end

    always_comb
    begin
        next_state = state;
        next_state.tick = 1'b0;
        if (sync_clear)
        begin
            next_state.count = '0;
        end
        else if (state.count == LAST)
        begin
            next_state.count = '0;
            next_state.tick  = 1'b1;
        end
        else
        begin
            next_state.count = state.count + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign tick = state.tick;
endmodule

// >>> rtl/ltc_gate.sv
// configurable two-input gate of one grid position
`timescale 1ns/1ps
module ltc_gate
    import ltc_pkg::*;
(
    input  wire logic         in_a,
    input  wire logic         in_b,
    input  wire ltc_gate_type kind,
    output logic              result
);
    always_comb
    begin
        case (kind)
            LTC_GATE_AND:  result = in_a & in_b;
            LTC_GATE_OR:   result = in_a | in_b;
            LTC_GATE_XOR:  result = in_a ^ in_b;
            LTC_GATE_NAND: result = ~(in_a & in_b);
            LTC_GATE_NOR:  result = ~(in_a | in_b);
            LTC_GATE_XNOR: result = ~(in_a ^ in_b);
            default:       result = 1'b0;
        endcase
    end
endmodule

// >>> rtl/ltc_blocks.sv
// tick-driven timers, counters and the output stage of a logic sheet
`timescale 1ns/1ps
// Overview of operation
// - on-delay output rises only after trigger seen high on preset_time successive ticks
// - on-delay output drops at once on low trigger; timing restarts from zero
// - off-delay output goes high on each trigger rising edge
// - off-delay output stays high preset_time after trigger falls, then clears
// - pulse generator toggles, preset_time high and preset_time low
// - pulse generator runs only while trigger is high, else output low
// - one-shot high preset_time after rising edge; edges while high ignored
// - retriggerable one-shot restarts full preset_time on each rising edge
// - up counter adds one per up_pulse edge while below preset_count
// - up counter saturates at preset_count
// - up counter wipe edge clears count and beats a simultaneous up_pulse
// - up counter output high while count at or above preset_count
// - down counter subtracts one per down_pulse edge while above zero
// - down counter never goes below zero
// - reload_pulse edge loads preset_count and beats a simultaneous down_pulse
// - down counter output high while count is zero
// - sheet output may assert up to four selected trigger events
// - each grid position is one of six two-input gate types
// - preset times count whole ticks; timing advances once per tick
module ltc_blocks
    import ltc_pkg::*;
#(
    parameter int unsigned TW           = TIME_WIDTH,
    parameter int unsigned CW           = COUNT_WIDTH,
    parameter int unsigned TICK_DIVIDE  = TICK_CYCLES,
    parameter logic [TW-1:0] PRESET_TIME  = TW'(PRESET_TIME_DEFAULT),
    parameter logic [CW-1:0] PRESET_COUNT = CW'(PRESET_COUNT_DEFAULT)
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   sync_clear,
    input  wire logic                   on_delay_in,
    input  wire logic                   off_delay_in,
    input  wire logic                   pulse_gen_in,
    input  wire logic                   oneshot_in,
    input  wire logic                   retrig_in,
    input  wire logic                   up_pulse,
    input  wire logic                   up_wipe,
    input  wire logic                   down_pulse,
    input  wire logic                   reload_pulse,
    input  wire logic                   gate_in_a,
    input  wire logic                   gate_in_b,
    input  wire ltc_gate_type           gate_kind,
    input  wire logic [EVENT_COUNT-1:0] event_select,
    output logic                        on_delay_timer,
    output logic                        off_delay_timer,
    output logic                        pulse_gen,
    output logic                        oneshot_pulse,
    output logic                        retrig_oneshot,
    output logic                        up_counter,
    output logic                        down_counter,
    output logic [CW-1:0]               up_current_count,
    output logic [CW-1:0]               down_current_count,
    output logic                        sheet_out,
    output logic [EVENT_COUNT-1:0]      trigger_events
);
    localparam int NIN = 10;

    // synchronised input bundle order
    localparam int I_ON  = 0;
    localparam int I_OFF = 1;
    localparam int I_PG  = 2;
    localparam int I_OS  = 3;
    localparam int I_RT  = 4;
    localparam int I_UP  = 5;
    localparam int I_UW  = 6;
    localparam int I_DN  = 7;
    localparam int I_LD  = 8;
    localparam int I_GB  = 9;

    typedef struct packed {
        // input synchroniser and the sample of the last tick
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] prev;

        // tick counts of the five timers
        logic [TW-1:0]  on_cnt;
        logic [TW-1:0]  off_cnt;
        logic [TW-1:0]  pg_cnt;
        logic [TW-1:0]  os_cnt;
        logic [TW-1:0]  rt_cnt;

        // timer outputs
        logic           on_q;
        logic           off_q;
        logic           pg_q;
        logic           os_q;
        logic           rt_q;

        // counter values and flags
        logic [CW-1:0]  up_cv;
        logic [CW-1:0]  dn_cv;
        logic           up_q;
        logic           dn_q;

        // sheet output stage
        logic           sheet_q;
        logic [EVENT_COUNT-1:0] events_q;
    } ltc_state_type;

    ltc_state_type state;
    ltc_state_type next_state;

    logic          tick;
    logic          gate_result;
    logic [NIN-1:0] raw_in;

    // refuse settings that the counters and the divider cannot serve
    if (TW < 1 || CW < 1)
    begin
        $error("preset widths must be at least one bit");
    end
    if (TICK_DIVIDE < 1)
    begin
        $error("tick divide must be at least one");
    end
    if (PRESET_TIME == '0)
    begin
        $error("preset time must be at least one tick");
    end
    if (EVENT_COUNT < 1 || EVENT_COUNT > 4)
    begin
        $error("a sheet serves one to four trigger events");
    end

    ltc_tick_gen #(
        .DIVIDE     (TICK_DIVIDE)
    ) u_tick (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .sync_clear (sync_clear),
        .tick       (tick)
    );

    // gate sees the output of the on-delay timer and the synchronised gate_in_b pin
    ltc_gate u_gate (
        .in_a   (state.on_q),
        .in_b   (state.sync2[I_GB]),
        .kind   (gate_kind),
        .result (gate_result)
    );

    assign raw_in = {gate_in_b, reload_pulse, down_pulse, up_wipe, up_pulse,
                     retrig_in, oneshot_in, pulse_gen_in, off_delay_in, on_delay_in};

    // rising edge against the sample of the previous tick
    function automatic logic rose(input logic [NIN-1:0] cur,
                                  input logic [NIN-1:0] old,
                                  input int             idx);
        rose = cur[idx] & ~old[idx];
    endfunction

    // a timer count has reached the preset
    function automatic logic at_preset(input logic [TW-1:0] cnt);
        at_preset = (cnt == PRESET_TIME);
    endfunction

    // timer counter step that stops at the preset
    function automatic logic [TW-1:0] step(input logic [TW-1:0] cnt);
        step = at_preset(cnt) ? cnt : cnt + TW'(1);
    endfunction

    logic [NIN-1:0] cur;

    always_comb
    begin
        cur = state.sync2;
        next_state = state;
        next_state.sync1 = raw_in;
        next_state.sync2 = state.sync1;

        if (sync_clear)
        begin
            next_state = '0;
            next_state.sync1 = raw_in;
            next_state.sync2 = state.sync1;
        end
        else if (tick)
        begin
            next_state.prev = cur;

            // on-delay: count while high, output at preset
            // limitation: the first high tick counts whole, so the wait may be short of a tick
            if (!cur[I_ON])
            begin
                next_state.on_cnt = '0;
                next_state.on_q   = 1'b0;
            end
            else
            begin
                next_state.on_cnt = step(state.on_cnt);
                next_state.on_q   = at_preset(step(state.on_cnt));
            end

            // off-delay: edge sets, low phase counts out
            // a new edge during the hold clears the count, so the hold starts over
            if (rose(cur, state.prev, I_OFF))
            begin
                next_state.off_q   = 1'b1;
                next_state.off_cnt = '0;
            end
            else if (cur[I_OFF])
            begin
                next_state.off_cnt = '0;
            end
            else if (state.off_q)
            begin
                next_state.off_cnt = step(state.off_cnt);
                if (at_preset(step(state.off_cnt)))
                    next_state.off_q = 1'b0;
            end

            // pulse generator
            // the first high tick opens a high phase, so the wave lines up with the trigger
            if (!cur[I_PG])
            begin
                next_state.pg_q   = 1'b0;
                next_state.pg_cnt = '0;
            end
            else if (!state.prev[I_PG])
            begin
                next_state.pg_q   = 1'b1;
                next_state.pg_cnt = TW'(1);
            end
            else if (at_preset(state.pg_cnt))
            begin
                next_state.pg_q   = ~state.pg_q;
                next_state.pg_cnt = TW'(1);
            end
            else
            begin
                next_state.pg_cnt = state.pg_cnt + TW'(1);
            end

            // non-retriggerable one-shot
            // the running pulse is served first, which is what makes edges while high ignored
            if (state.os_q)
            begin
                if (at_preset(state.os_cnt))
                begin
                    next_state.os_q   = 1'b0;
                    next_state.os_cnt = '0;
                end
                else
                begin
                    next_state.os_cnt = state.os_cnt + TW'(1);
                end
            end
            else if (rose(cur, state.prev, I_OS))
            begin
                next_state.os_q   = 1'b1;
                next_state.os_cnt = TW'(1);
            end

            // retriggerable one-shot: every edge restarts
            // the edge is tested first, so a restart beats expiry in the same tick
            if (rose(cur, state.prev, I_RT))
            begin
                next_state.rt_q   = 1'b1;
                next_state.rt_cnt = TW'(1);
            end
            else if (state.rt_q)
            begin
                if (at_preset(state.rt_cnt))
                begin
                    next_state.rt_q   = 1'b0;
                    next_state.rt_cnt = '0;
                end
                else
                begin
                    next_state.rt_cnt = state.rt_cnt + TW'(1);
                end
            end

            // up counter, wipe first
            if (rose(cur, state.prev, I_UW))
                next_state.up_cv = '0;
            else if (rose(cur, state.prev, I_UP) && state.up_cv < PRESET_COUNT)
                next_state.up_cv = state.up_cv + CW'(1);

            // down counter, reload first
            if (rose(cur, state.prev, I_LD))
                next_state.dn_cv = PRESET_COUNT;
            else if (rose(cur, state.prev, I_DN) && state.dn_cv != '0)
                next_state.dn_cv = state.dn_cv - CW'(1);
        end

        next_state.up_q = (next_state.up_cv >= PRESET_COUNT);
        next_state.dn_q = (next_state.dn_cv == '0);

        // sheet output drives relay level and selected trigger events
        next_state.sheet_q  = gate_result;
        next_state.events_q = gate_result ? event_select : '0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    // every output is a field of the state register
    assign on_delay_timer     = state.on_q;
    assign off_delay_timer    = state.off_q;
    assign pulse_gen          = state.pg_q;
    assign oneshot_pulse      = state.os_q;
    assign retrig_oneshot     = state.rt_q;
    assign up_counter         = state.up_q;
    assign down_counter       = state.dn_q;
    assign up_current_count   = state.up_cv;
    assign down_current_count = state.dn_cv;
    assign sheet_out          = state.sheet_q;
    assign trigger_events     = state.events_q;
endmodule

// >>> test/ltc_blocks_checker.sv
// port-level assertions for the logic timer and counter blocks
`timescale 1ns/1ps
module ltc_blocks_checker
    import ltc_pkg::*;
#(
    parameter int unsigned   TW           = TIME_WIDTH,
    parameter int unsigned   CW           = COUNT_WIDTH,
    parameter int unsigned   TICK_DIVIDE  = TICK_CYCLES,
    parameter logic [TW-1:0] PRESET_TIME  = TW'(PRESET_TIME_DEFAULT),
    parameter logic [CW-1:0] PRESET_COUNT = CW'(PRESET_COUNT_DEFAULT)
)
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          sync_clear,
    input  wire logic          on_delay_in,
    input  wire logic          pulse_gen_in,
    input  wire logic          on_delay_timer,
    input  wire logic          pulse_gen,
    input  wire logic          oneshot_pulse,
    input  wire logic          up_counter,
    input  wire logic          down_counter,
    input  wire logic [CW-1:0] up_current_count,
    input  wire logic [CW-1:0] down_current_count
);
    localparam int unsigned SPAN = PRESET_TIME * TICK_DIVIDE;
    int unsigned hi_run;
    int unsigned os_len;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_run <= 0;
            os_len <= 0;
        end
        else
        begin
            hi_run <= on_delay_in ? hi_run + 1 : 0;
            os_len <= oneshot_pulse ? os_len + 1 : 0;
        end
    end
    a_ondly_drop: assert property (!on_delay_in [*8] |-> !on_delay_timer)
        else $error("on-delay output high with trigger low");
    a_ondly_rise: assert property ($rose(on_delay_timer) |->
        hi_run >= (PRESET_TIME - 1) * TICK_DIVIDE)
        else $error("on-delay output rose too early");
    a_pulse_idle: assert property (!pulse_gen_in [*8] |-> !pulse_gen)
        else $error("pulse output high with trigger low");
    a_oneshot_len: assert property ($fell(oneshot_pulse) |-> os_len == SPAN)
        else $error("one-shot pulse length wrong");
    a_upcnt_sat: assert property (up_current_count <= PRESET_COUNT)
        else $error("up count above preset");
    a_upcnt_step: assert property (up_current_count != $past(up_current_count) |->
        (up_current_count - $past(up_current_count)) == CW'(1) || up_current_count == '0)
        else $error("up count moved by other than one");
    a_dncnt_step: assert property (down_current_count != $past(down_current_count) |->
        ($past(down_current_count) - down_current_count) == CW'(1)
        || down_current_count == PRESET_COUNT || $past(sync_clear))
        else $error("down count moved by other than one");
    a_dncnt_out: assert property (down_current_count == '0 |-> ##[0:1] down_counter)
        else $error("down output low at zero count");
    cover property ($rose(on_delay_timer));
    cover property ($rose(up_counter));
    cover property ($fell(oneshot_pulse));
endmodule
bind ltc_blocks ltc_blocks_checker #(
    .TW(TW), .CW(CW), .TICK_DIVIDE(TICK_DIVIDE),
    .PRESET_TIME(PRESET_TIME), .PRESET_COUNT(PRESET_COUNT)
) u_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .sync_clear(sync_clear),
    .on_delay_in(on_delay_in), .pulse_gen_in(pulse_gen_in),
    .on_delay_timer(on_delay_timer), .pulse_gen(pulse_gen),
    .oneshot_pulse(oneshot_pulse), .up_counter(up_counter),
    .down_counter(down_counter), .up_current_count(up_current_count),
    .down_current_count(down_current_count)
);

// >>> test/ltc_relay_model.sv
// relay and event sink standing at the sheet output
`timescale 1ns/1ps
module ltc_relay_model
    import ltc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   sheet_out,
    input  wire logic [EVENT_COUNT-1:0] trigger_events,
    output logic                        relay,
    output logic [EVENT_COUNT-1:0]      events_seen
);
    // sticky so a single-tick event is not lost
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relay       <= 1'b0;
            events_seen <= '0;
        end
        else
        begin
            relay       <= sheet_out;
            events_seen <= events_seen | trigger_events;
        end
    end
endmodule

// >>> test/logic_timer_counter_blocks_tb_top.sv
// self-checking bench for the logic timer and counter blocks
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %0h want %0h", $time, got, exp); end end
module logic_timer_counter_blocks_tb_top;
    import ltc_pkg::*;
    logic         sys_clk = 0, rst_n = 0, sync_clear = 0;
    logic         on_in = 0, off_in = 0, pg_in = 0, os_in = 0, rt_in = 0;
    logic         up_p = 0, wipe = 0, dn_p = 0, rl = 0, gate_b = 0;
    ltc_gate_type kind = LTC_GATE_AND;
    logic [3:0]   sel = 4'hA, ev, seen;
    logic         on_q, off_q, pg_q, os_q, rt_q, up_q, dn_q, sh_q, relay;
    logic [15:0]  up_cv, dn_cv;
    int           error_cnt = 0, total_checks = 0, na, nb, n;
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) na += (os_q === 1'b1);
    always @(negedge sys_clk) nb += (rt_q === 1'b1);
    // small divider and presets keep every timing a few cycles long
    ltc_blocks #(.TICK_DIVIDE(4), .PRESET_TIME(16'h0003), .PRESET_COUNT(16'h0003)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sync_clear(sync_clear),
        .on_delay_in(on_in), .off_delay_in(off_in), .pulse_gen_in(pg_in),
        .oneshot_in(os_in), .retrig_in(rt_in), .up_pulse(up_p), .up_wipe(wipe),
        .down_pulse(dn_p), .reload_pulse(rl), .gate_in_a(1'b0), .gate_in_b(gate_b),
        .gate_kind(kind), .event_select(sel), .on_delay_timer(on_q),
        .off_delay_timer(off_q), .pulse_gen(pg_q), .oneshot_pulse(os_q),
        .retrig_oneshot(rt_q), .up_counter(up_q), .down_counter(dn_q),
        .up_current_count(up_cv), .down_current_count(dn_cv), .sheet_out(sh_q),
        .trigger_events(ev));
    ltc_relay_model partner (.sys_clk(sys_clk), .rst_n(rst_n), .sheet_out(sh_q),
        .trigger_events(ev), .relay(relay), .events_seen(seen));
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // two ticks high then two ticks low, so each edge is seen once
    task automatic pulse(input logic [3:0] m);
        @(posedge sys_clk) {up_p, wipe, dn_p, rl} <= m;
        cyc(8);
        @(posedge sys_clk) {up_p, wipe, dn_p, rl} <= 4'h0;
        cyc(8);
    endtask
    task automatic run(input logic v, output int k);
        for (k = 0; k < 64 && pg_q === v; k++)
            cyc(1);
        if (k == 64)
        begin
            error_cnt++;
            $display("[ERR] %0t pulse output stuck", $time);
            summarize();
        end
    endtask
    function automatic logic gref(input int k, input logic a, input logic b);
        case (k)
            0: return a & b;
            1: return a | b;
            2: return a ^ b;
            3: return ~(a & b);
            4: return ~(a | b);
            default: return ~(a ^ b);
        endcase
    endfunction
    task automatic t_timers();
        @(posedge sys_clk) on_in <= 1'b1;
        cyc(5);
        @(posedge sys_clk) on_in <= 1'b0;
        cyc(4);
        `CHK(on_q, 1'b0)
        @(posedge sys_clk) on_in <= 1'b1;
        cyc(9);
        `CHK(on_q, 1'b0)
        cyc(8);
        `CHK(on_q, 1'b1)
        @(posedge sys_clk) {on_in, off_in} <= 2'b01;
        cyc(8);
        `CHK(on_q, 1'b0)
        `CHK(off_q, 1'b1)
        @(posedge sys_clk) off_in <= 1'b0;
        cyc(8);
        `CHK(off_q, 1'b1)
        cyc(16);
        `CHK(off_q, 1'b0)
    endtask
    task automatic t_pulse();
        @(posedge sys_clk) pg_in <= 1'b1;
        run(1'b0, n);
        run(1'b1, n);
        `CHK(n, 12)
        run(1'b0, n);
        `CHK(n, 12)
        @(posedge sys_clk) pg_in <= 1'b0;
        cyc(8);
        `CHK(pg_q, 1'b0)
    endtask
    // second edge two ticks after the first, inside the high phase
    task automatic t_shots();
        na = 0;
        nb = 0;
        @(posedge sys_clk) {os_in, rt_in} <= 2'b11;
        repeat (3) @(posedge sys_clk);
        @(posedge sys_clk) {os_in, rt_in} <= 2'b00;
        repeat (3) @(posedge sys_clk);
        @(posedge sys_clk) {os_in, rt_in} <= 2'b11;
        cyc(48);
        `CHK(na, 12)
        `CHK(nb, 20)
        @(posedge sys_clk) {os_in, rt_in} <= 2'b00;
    endtask
    task automatic t_counters();
        cyc(1);
        `CHK(dn_q, 1'b1)
        repeat (2) pulse(4'h8);
        `CHK(up_cv, 16'h0002)
        `CHK(up_q, 1'b0)
        repeat (2) pulse(4'h8);
        `CHK(up_cv, 16'h0003)
        `CHK(up_q, 1'b1)
        pulse(4'hC);
        `CHK(up_cv, 16'h0000)
        `CHK(up_q, 1'b0)
        pulse(4'h2);
        `CHK(dn_cv, 16'h0000)
        pulse(4'h1);
        `CHK(dn_cv, 16'h0003)
        `CHK(dn_q, 1'b0)
        pulse(4'h2);
        `CHK(dn_cv, 16'h0002)
        pulse(4'h3);
        `CHK(dn_cv, 16'h0003)
        repeat (3) pulse(4'h2);
        `CHK(dn_q, 1'b1)
        pulse(4'h8);
        @(posedge sys_clk) sync_clear <= 1'b1;
        @(posedge sys_clk) sync_clear <= 1'b0;
        cyc(1);
        `CHK(up_cv, 16'h0000)
    endtask
    task automatic t_gate();
        for (int a = 0; a < 2; a++)
        begin
            @(posedge sys_clk) on_in <= a[0];
            cyc(20);
            for (int k = 0; k < 6; k++)
                for (int b = 0; b < 2; b++)
                begin
                    @(posedge sys_clk) {kind, gate_b} <= {ltc_gate_type'(k), b[0]};
                    cyc(12);
                    `CHK(sh_q, gref(k, a[0], b[0]))
                    `CHK(ev, gref(k, a[0], b[0]) ? sel : 4'h0)
                    `CHK(relay, gref(k, a[0], b[0]))
                end
        end
        // codes beyond the six gate kinds give a low sheet output
        @(posedge sys_clk) kind <= ltc_gate_type'(3'h6);
        cyc(12);
        `CHK(sh_q, 1'b0)
        `CHK(seen, 4'hA)
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(2);
        t_timers();
        t_pulse();
        t_shots();
        t_counters();
        t_gate();
        summarize();
    end
endmodule
